/* File: verilog/tmcs_ctrl_status.sv */
`timescale 1ns/1ps
module tmcs_ctrl_status #(
   parameter longint SLOW_CYC = tmcs_pkg::SLOW_PERIOD_CYC
) (
   // Clock, reset, enable
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       clockEnable,
   // Register access from the serial engine
   input  wire logic [7:0] command,
   input  wire logic       writeStrobe,
   input  wire logic [7:0] writeData,
   output logic [7:0]      readData,
   // Converter handshake
   output logic            convStart,
   input  wire logic       convDone,
   // Compare results, valid with convDone
   input  wire logic       localOver,
   input  wire logic       localUnder,
   input  wire logic       localCrit,
   input  wire logic       remoteOver,
   input  wire logic       remoteUnder,
   input  wire logic       remoteCrit,
   input  wire logic       diodeOpen,
   // Flag clear from the serial engine after a status read
   input  wire logic       flagsReadAck,
   // Outputs
   output logic            alarmOut,
   output logic            critical_out_n
);
   logic [7:0] deviceSetup;
   logic [3:0] sampleInterval;
   logic       busy;
   logic       oneShotPend;
   logic [6:0] flagBits;
   logic       rateTick;
   logic       remOverQ;
   logic       remUnderQ;
   logic       remCritQ;
   logic       running;
   logic [7:0] conditionFlags;

   assign running = !deviceSetup[tmcs_pkg::SET_STANDBY];

   // ----------------------------------------------------------------
   // Setup and interval registers
   // ----------------------------------------------------------------
   // Unused bits are masked on write so they can never read back set
   always_ff @(posedge clock) begin
      if (reset) begin
         deviceSetup    <= tmcs_pkg::SETUP_RESET;
         sampleInterval <= tmcs_pkg::INTERVAL_RESET;
      end else if (clockEnable && writeStrobe) begin
         if (command == tmcs_pkg::CMD_SETUP_WR) begin
            deviceSetup <= writeData & tmcs_pkg::SETUP_USED_MASK;
         end else if (command == tmcs_pkg::CMD_INTERVAL_WR) begin
            sampleInterval <= writeData[3:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Conversion scheduling
   // ----------------------------------------------------------------
   tmcs_rate_timer #(
      .SLOW_CYC    (SLOW_CYC)
   ) u_timer (
      .clock       (clock),
      .reset       (reset),
      .clockEnable (clockEnable),
      .run         (running),
      .code        (sampleInterval),
      .tick        (rateTick)
   );

   // One-shot request is held until the converter is idle
   always_ff @(posedge clock) begin
      if (reset) begin
         oneShotPend <= 1'b0;
      end else if (clockEnable) begin
         if (writeStrobe && command == tmcs_pkg::CMD_ONE_SHOT) begin
            oneShotPend <= 1'b1;
         end else if (convStart) begin
            oneShotPend <= 1'b0;
         end
      end
   end

   // Start pulse: periodic tick or one-shot, only when idle
   assign convStart = clockEnable && !busy
                      && ((rateTick && running) || oneShotPend);

   // Busy spans start to done
   always_ff @(posedge clock) begin
      if (reset) begin
         busy <= 1'b0;
      end else if (clockEnable) begin
         if (convStart) begin
            busy <= 1'b1;
         end else if (convDone) begin
            busy <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Remote fault queue
   // ----------------------------------------------------------------
   tmcs_fault_queue u_qOver (
      .clock       (clock),
      .reset       (reset),
      .clockEnable (clockEnable),
      .sample      (convDone),
      .outside     (remoteOver),
      .needThree   (deviceSetup[tmcs_pkg::SET_FAULT_QUEUE]),
      .trip        (remOverQ)
   );
   tmcs_fault_queue u_qUnder (
      .clock       (clock),
      .reset       (reset),
      .clockEnable (clockEnable),
      .sample      (convDone),
      .outside     (remoteUnder),
      .needThree   (deviceSetup[tmcs_pkg::SET_FAULT_QUEUE]),
      .trip        (remUnderQ)
   );
   tmcs_fault_queue u_qCrit (
      .clock       (clock),
      .reset       (reset),
      .clockEnable (clockEnable),
      .sample      (convDone),
      .outside     (remoteCrit),
      .needThree   (deviceSetup[tmcs_pkg::SET_FAULT_QUEUE]),
      .trip        (remCritQ)
   );

   // ----------------------------------------------------------------
   // Condition flags
   // ----------------------------------------------------------------
   // Sticky until a status read; a new event in the clear cycle wins
   always_ff @(posedge clock) begin
      if (reset) begin
         flagBits <= 7'd0;
      end else if (clockEnable) begin
         flagBits <= (flagsReadAck ? 7'd0 : flagBits)
                     | (convDone ? {localOver, localUnder,
                                    remOverQ, remUnderQ,
                                    diodeOpen,
                                    remCritQ, localCrit}
                                 : 7'd0);
      end
   end

   assign conditionFlags = {busy, flagBits};

   // ----------------------------------------------------------------
   // Alarm and critical outputs
   // ----------------------------------------------------------------
   // Registered so the pins never glitch on a flag update
   always_ff @(posedge clock) begin
      if (reset) begin
         alarmOut       <= 1'b0;
         critical_out_n <= 1'b1;
      end else if (clockEnable) begin
         alarmOut <= !deviceSetup[tmcs_pkg::SET_ALARM_MASK]
                     && |(conditionFlags & tmcs_pkg::ALARM_SRC_MASK);
         critical_out_n <= !((flagBits[tmcs_pkg::FLG_REM_CRIT]
                              && !deviceSetup[tmcs_pkg::SET_REMOTE_CRITICAL_FLAG_MASK])
                             || (flagBits[tmcs_pkg::FLG_LOC_CRIT]
                              && !deviceSetup[tmcs_pkg::SET_LOCAL_CRITICAL_FLAG_MASK]));
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         readData <= tmcs_pkg::UNMAPPED_RDATA;
      end else if (clockEnable) begin
         if (command == tmcs_pkg::CMD_FLAGS_RD) begin
            readData <= conditionFlags;
         end else if (command == tmcs_pkg::CMD_SETUP_RD) begin
            readData <= deviceSetup;
         end else if (command == tmcs_pkg::CMD_INTERVAL_RD) begin
            readData <= {4'h0, sampleInterval};
         end else if (command == tmcs_pkg::CMD_ONE_SHOT) begin
            readData <= tmcs_pkg::ONE_SHOT_RDATA;
         end else begin
            readData <= tmcs_pkg::UNMAPPED_RDATA;
         end
      end
   end
endmodule

/* File: verilog/tmcs_pkg.sv */
package tmcs_pkg;
   // -----------------------------------------------------------------
   // Command codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_FLAGS_RD    = 8'h02;
   localparam logic [7:0] CMD_SETUP_RD    = 8'h03;
   localparam logic [7:0] CMD_INTERVAL_RD = 8'h04;
   localparam logic [7:0] CMD_SETUP_WR    = 8'h09;
   localparam logic [7:0] CMD_INTERVAL_WR = 8'h0A;
   localparam logic [7:0] CMD_ONE_SHOT    = 8'h0F;
   localparam logic [7:0] ONE_SHOT_RDATA  = 8'hFF;
   localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;

   // -----------------------------------------------------------------
   // Reset values and field layout
   // -----------------------------------------------------------------
   localparam logic [7:0] SETUP_RESET     = 8'h00;
   localparam logic [7:0] SETUP_USED_MASK = 8'hD5;
   localparam logic [3:0] INTERVAL_RESET  = 4'h8;
   localparam logic [3:0] INTERVAL_MAX    = 4'h9;
   localparam int         INTERVAL_W      = 4;
   localparam int         SET_ALARM_MASK  = 7;
   localparam int         SET_STANDBY     = 6;
   localparam int         SET_REMOTE_CRITICAL_FLAG_MASK  = 4;
   localparam int         SET_LOCAL_CRITICAL_FLAG_MASK  = 2;
   localparam int         SET_FAULT_QUEUE = 0;
   localparam int         FLG_BUSY        = 7;
   localparam int         FLG_LOC_OVER    = 6;
   localparam int         FLG_LOC_UNDER   = 5;
   localparam int         FLG_REM_OVER    = 4;
   localparam int         FLG_REM_UNDER   = 3;
   localparam int         FLG_OPEN        = 2;
   localparam int         FLG_REM_CRIT    = 1;
   localparam int         FLG_LOC_CRIT    = 0;
   localparam logic [7:0] ALARM_SRC_MASK  = 8'h7B;
   localparam logic [1:0] QUEUE_DEPTH     = 2'd3;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam longint CLOCK_HZ        = 64'd10_000_000;
   // Slowest period, code 0: 16 s (0.0625 Hz); each code step up to 9 halves it
   localparam longint SLOW_PERIOD_S   = 64'd16;
   localparam longint SLOW_PERIOD_CYC = SLOW_PERIOD_S * CLOCK_HZ;
   localparam int     PERIOD_W        = 28;
   localparam int     QUIET_W         = 2;
endpackage

/* File: verilog/tmcs_fault_queue.sv */
`timescale 1ns/1ps
module tmcs_fault_queue (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic clockEnable,
   // Compare event
   input  wire logic sample,
   input  wire logic outside,
   input  wire logic needThree,
   // Qualified result
   output logic      trip
);
   logic [1:0] runCount;

   // ----------------------------------------------------------------
   // Consecutive out-of-limit counter
   // ----------------------------------------------------------------
   // Saturates at three; an in-limit sample restarts the run
   always_ff @(posedge clock) begin
      if (reset) begin
         runCount <= 2'd0;
      end else if (clockEnable && sample) begin
         if (!outside) begin
            runCount <= 2'd0;
         end else if (runCount != tmcs_pkg::QUEUE_DEPTH) begin
            runCount <= runCount + 2'd1;
         end
      end
   end

   // Single-sample or three-in-a-row qualification
   always_comb begin
      if (needThree) begin
         trip = outside && (runCount == (tmcs_pkg::QUEUE_DEPTH - 2'd1)
                || runCount == tmcs_pkg::QUEUE_DEPTH);
      end else begin
         trip = outside;
      end
   end
endmodule

/* File: verilog/tmcs_rate_timer.sv */
`timescale 1ns/1ps
module tmcs_rate_timer #(
   parameter longint SLOW_CYC = tmcs_pkg::SLOW_PERIOD_CYC
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       clockEnable,
   // Control
   input  wire logic       run,
   input  wire logic [3:0] code,
   // Tick out
   output logic            tick
);
   logic [27:0] count;
   logic [27:0] limit;

   // Period in cycles less one for an interval code; undefined codes take 32 Hz
   function automatic logic [27:0] periodOf(input logic [3:0] c);
      logic [3:0] k;
      k = (c > tmcs_pkg::INTERVAL_MAX) ? tmcs_pkg::INTERVAL_MAX : c;
      return 28'((SLOW_CYC >> k) - 64'd1);
   endfunction

   assign limit = periodOf(code);

   // ----------------------------------------------------------------
   // Free-running period counter
   // ----------------------------------------------------------------
   // Restarts from zero whenever standby stops it
   always_ff @(posedge clock) begin
      if (reset) begin
         count <= 28'd0;
         tick  <= 1'b0;
      end else if (clockEnable) begin
         tick <= 1'b0;
         if (!run) begin
            count <= 28'd0;
         end else if (count >= limit) begin
            count <= 28'd0;
            tick  <= 1'b1;
         end else begin
            count <= count + 28'd1;
         end
      end
   end
endmodule

/* File: bench/tmcs_ctrl_status_assertions.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Port checker for the control and status bank
// ---------------------------------------------
module tmcs_ctrl_status_assertions (
   // Clock and reset
   input wire logic       clock,
   input wire logic       reset,
   input wire logic       clockEnable,
   // Register access
   input wire logic [7:0] command,
   input wire logic       writeStrobe,
   input wire logic [7:0] writeData,
   input wire logic [7:0] readData,
   // Converter results
   input wire logic       convDone,
   input wire logic       localOver,
   input wire logic       localCrit,
   // Outputs
   input wire logic       alarmOut,
   input wire logic       critical_out_n
);
   // Shadow setup byte, so masks can be judged from the ports alone
   logic [7:0] setupCopy;
   always_ff @(posedge clock) begin
      if (reset) begin
         setupCopy <= 8'h00;
      end else if (clockEnable && writeStrobe && command == tmcs_pkg::CMD_SETUP_WR) begin
         setupCopy <= writeData;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   property p_one_shot_read; clockEnable && command == tmcs_pkg::CMD_ONE_SHOT |=> readData == 8'hFF; endproperty
   a_one_shot_read: assert property (p_one_shot_read) else $error("one-shot read not FF");
   property p_unmapped_read; clockEnable && command >= 8'h10 |=> readData == 8'h00; endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not 00");
   property p_interval_upper; clockEnable && command == 8'h04 |=> readData[7:4] == 4'h0; endproperty
   a_interval_upper: assert property (p_interval_upper) else $error("interval upper bits set");
   property p_setup_reserved; clockEnable && command == 8'h03 |=> (readData & 8'h2A) == 8'h00; endproperty
   a_setup_reserved: assert property (p_setup_reserved) else $error("setup spare bits set");
   property p_setup_readback;
      clockEnable && writeStrobe && command == 8'h09 ##1 clockEnable && command == 8'h03
         |=> readData == ($past(writeData, 2) & 8'hD5);
   endproperty
   a_setup_readback: assert property (p_setup_readback) else $error("setup readback wrong");
   property p_alarm_mask; clockEnable && setupCopy[7] |=> !alarmOut; endproperty
   a_alarm_mask: assert property (p_alarm_mask) else $error("alarm not masked");
   property p_crit_mask; clockEnable && setupCopy[4] && setupCopy[2] |=> critical_out_n; endproperty
   a_crit_mask: assert property (p_crit_mask) else $error("critical not masked");
   property p_local_alarm;
      convDone && localOver && clockEnable ##1 clockEnable && !setupCopy[7] |=> alarmOut;
   endproperty
   a_local_alarm: assert property (p_local_alarm) else $error("local over gave no alarm");
   property p_local_crit;
      convDone && localCrit && clockEnable ##1 clockEnable && !setupCopy[2] |=> !critical_out_n;
   endproperty
   a_local_crit: assert property (p_local_crit) else $error("local critical not driven");

   // Main scenarios reached
   c_one_shot: cover property (clockEnable && writeStrobe && command == 8'h0F);
   c_local_over: cover property (convDone && localOver);
   c_crit_low: cover property (!critical_out_n);
endmodule

/* File: bench/tmcs_conv_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Converter stand-in: answers each start after 2 or 6 cycles
// ---------------------------------------------
module tmcs_conv_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Handshake
   input  wire logic       convStart,
   input  wire logic       slowAnswer,
   output logic            convDone,
   // Compare results
   input  wire logic [6:0] resultSet,
   output logic [6:0]      results
);
   logic [3:0] left;
   // Countdown to done; results toggle outside the done pulse so stale use shows
   always_ff @(posedge clock) begin
      if (reset) begin
         left     <= 4'h0;
         convDone <= 1'b0;
         results  <= 7'h00;
      end else begin
         convDone <= (left == 4'h1);
         results  <= (left == 4'h1) ? resultSet : ~results;
         if (convStart && left == 4'h0) begin
            left <= slowAnswer ? 4'h6 : 4'h2;
         end else if (left != 4'h0) begin
            left <= left - 4'h1;
         end
      end
   end
endmodule

/* File: bench/tmcs_ctrl_status_tb.sv */
`timescale 1ns/1ps
module tmcs_ctrl_status_tb;
   localparam longint SLOW = 4096; // Short slow period keeps the run brief
   logic       clock = 0, reset = 1, writeStrobe = 0, flagsReadAck = 0, slowAnswer = 0;
   logic [7:0] command = 0, writeData = 0, readData;
   logic [6:0] resultSet = 0, results;
   logic       clockEnable = 1;
   logic       convStart, convDone, alarmOut, critical_out_n, alarmSeen, critSeen, busySeen;
   int         err_total = 0, comparisons = 0, cycles = 0, n;

   always #50 clock = ~clock;

   tmcs_ctrl_status #(.SLOW_CYC(SLOW)) uut (.clock(clock), .reset(reset),
      .clockEnable(clockEnable),
      .command(command), .writeStrobe(writeStrobe), .writeData(writeData), .readData(readData),
      .convStart(convStart), .convDone(convDone), .localOver(results[6]),
      .localUnder(results[5]), .localCrit(results[0]), .remoteOver(results[4]),
      .remoteUnder(results[3]), .remoteCrit(results[1]), .diodeOpen(results[2]),
      .flagsReadAck(flagsReadAck), .alarmOut(alarmOut), .critical_out_n(critical_out_n));
   tmcs_conv_model conv (.clock(clock), .reset(reset), .convStart(convStart),
      .slowAnswer(slowAnswer), .convDone(convDone), .resultSet(resultSet), .results(results));

   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Tasks enter and leave just after a rising edge
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      // Back-to-back writes let one edge pass so the strobe is never set twice at once
      if (writeStrobe === 1'b1) begin
         @(posedge clock);
      end
      command <= c;
      writeData <= d;
      writeStrobe <= 1;
      @(posedge clock);
      writeStrobe <= 0;
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] exp, input string name);
      command <= c;
      @(posedge clock);
      @(negedge clock);
      alarmSeen = alarmOut;
      critSeen = critical_out_n;
      chk(name, exp, readData);
      @(posedge clock);
   endtask
   task automatic one_shot(input logic [6:0] res);
      resultSet <= res;
      wr(8'h0F, 8'hA5);
      command <= 8'h02;
      busySeen = 0;
      // Skip the FF answer to the one-shot code, which would fake a busy bit
      @(posedge clock);
      for (n = 0; n < 30 && convDone !== 1'b1; n++) begin
         @(negedge clock);
         busySeen |= (readData[7] === 1'b1);
      end
      chk("busy seen", 8'h01, {7'h00, busySeen});
      repeat (3) @(posedge clock);
   endtask
   task automatic clear_flags;
      flagsReadAck <= 1;
      @(posedge clock);
      flagsReadAck <= 0;
   endtask
   task automatic flags_case(input logic [7:0] set, input logic [6:0] res, input logic [7:0] exp,
                             input logic al, input logic cr);
      wr(8'h09, set);
      one_shot(res);
      rd(8'h02, exp, "flags");
      chk("alarm", {7'h00, al}, {7'h00, alarmSeen});
      chk("critical", {7'h00, cr}, {7'h00, critSeen});
   endtask

   // Reset values, spare bits, standby, flags, queue, rates
   initial begin
      int codes[3] = '{8, 9, 12};
      repeat (8) @(posedge clock);
      reset <= 0;
      rd(8'h03, 8'h00, "setup reset");
      rd(8'h04, 8'h08, "interval reset");
      rd(8'h0F, 8'hFF, "one-shot read");
      rd(8'h33, 8'h00, "unmapped");
      chk("alarm reset", 8'h00, {7'h00, alarmSeen});
      chk("critical reset", 8'h01, {7'h00, critSeen});
      $display("test reset done");
      wr(8'h09, 8'hFF);
      rd(8'h03, 8'hD5, "setup spare");
      wr(8'h0A, 8'hFF);
      rd(8'h04, 8'h0F, "interval spare");
      wr(8'h09, 8'h40);
      wr(8'h03, 8'h80);
      rd(8'h03, 8'h40, "write to read code");
      clockEnable <= 0;
      wr(8'h09, 8'h00);
      clockEnable <= 1;
      rd(8'h03, 8'h40, "frozen write");
      repeat (20) @(posedge clock);
      rd(8'h02, 8'h00, "flags reset");
      busySeen = 0;
      for (n = 0; n < 100; n++) begin
         @(negedge clock);
         busySeen |= (convStart === 1'b1);
      end
      chk("standby starts", 8'h00, {7'h00, busySeen});
      @(posedge clock);
      $display("test setup and standby done");
      flags_case(8'h40, 7'h7F, 8'h7F, 1, 0);
      clear_flags();
      rd(8'h02, 8'h00, "flags cleared");
      flags_case(8'h40, 7'h04, 8'h04, 0, 1);
      clear_flags();
      flags_case(8'hD4, 7'h7F, 8'h7F, 0, 1);
      clear_flags();
      $display("test flags done");
      slowAnswer <= 1;
      // An in-limit result first breaks the run left by the mask test
      flags_case(8'h41, 7'h00, 8'h00, 0, 1);
      flags_case(8'h41, 7'h02, 8'h00, 0, 1);
      flags_case(8'h41, 7'h02, 8'h00, 0, 1);
      flags_case(8'h41, 7'h02, 8'h02, 1, 0);
      $display("test fault queue done");
      slowAnswer <= 0;
      wr(8'h09, 8'h00);
      foreach (codes[i]) begin
         wr(8'h0A, 8'(codes[i]));
         repeat (40) @(negedge clock);
         for (n = 0; n < 50 && convStart !== 1'b1; n++) @(negedge clock);
         for (n = 1; n < 50; n++) begin
            @(negedge clock);
            if (convStart === 1'b1) break;
         end
         chk("period", 8'(SLOW >> ((codes[i] > 9) ? 9 : codes[i])), 8'(n));
         @(posedge clock);
      end
      $display("test rates done");
      give_verdict();
   end
endmodule

bind tmcs_ctrl_status tmcs_ctrl_status_assertions chk_i (.clock(clock), .reset(reset),
   .clockEnable(clockEnable), .command(command), .writeStrobe(writeStrobe),
   .writeData(writeData), .readData(readData), .convDone(convDone), .localOver(localOver),
   .localCrit(localCrit), .alarmOut(alarmOut), .critical_out_n(critical_out_n));
